// ### adm_device.sv
// Analog die end: mode sequencer, wake-up selection, acquisition enables.
// Assumes the controller holds a link request until ack and drops it after.
// Functional notes
// - Eight-bit wake enable register, offset 0x06
// - Decode offsets on blocking and non-blocking bases
// - Acquisition control accepted only as word
// - Acquisition low byte enables, high byte masks
// - Reduced option keeps ext input 3 wake off
// - Reduced option keeps external temperature off
// - Select bit zero routes battery voltage sense
// - Normal, stop, sleep; full measurement in normal
// - Normal uses link clock; watchdog on oscillator
// - Stop: interface supply off, controller reduced
// - Sleep: both supplies off, watchdogs off
// - Each wake source selectable in low power
// - Current and temperature optional in low power
// - Wake exits pass through intermediate state
// - Intermediate may return straight to low power
// - Any die reset source forces reset state
// - Modes follow commands and enabled wake events
// - Mode 10 enters sleep
// - Mode 01 enters stop after link clock stops
// - Controller writes 00 to reach normal
// - Wake source recorded in readable flag
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module adm_device (
  input wire logic pclk,
  input wire logic presetn,
  adm_link_if.device link,
  input wire logic [7:0] wake_event,
  input wire logic cyclic_wake,
  input wire logic [1:0] reset_source,
  output logic interface_supply_on,
  output logic controller_supply_on,
  output logic controller_supply_reduced,
  output logic analog_clock_on_link,
  output logic watchdog_enable,
  output logic analog_blocks_on,
  output logic current_meas_enable,
  output logic voltage_meas_enable,
  output logic internal_temp_meas_enable,
  output logic external_temp_meas_enable,
  output logic conversion_irq_enable,
  output logic open_detect_enable,
  output logic optional_input_select,
  output logic amp_hour_counter_reset,
  output adm_pkg::adm_state_e mode_state
);
  import adm_pkg::*;

  adm_state_e state;
  logic [10:0] sync_a;
  logic [10:0] sync_b;
  logic [7:0] ev;
  logic cyc_ev;
  logic rst_any;
  logic ack_q;
  logic [7:0] wue;
  logic [7:0] acq;
  logic [7:0] mode;
  logic [7:0] wflag;
  logic cyc_flag;
  logic rst_flag;
  logic clk_link;
  logic acc;
  logic base_ok;
  logic [7:0] ofs;
  logic low_power;
  logic [7:0] wake_hit;
  logic cyc_hit;
  logic wake_any;
  logic mode_wr;
  logic acq_wr;
  logic [1:0] operating_mode_field;

  // Byte register hit: a byte write at its offset or a word write covering it
  function automatic logic hit(input logic [7:0] o, input logic [7:0] x);
    hit = acc && link.we && base_ok && ((!link.word && o == x) || (link.word && o == {x[7:1], 1'b0}));
  endfunction

  // Byte lane of the write data; big-endian, even address in the high lane
  function automatic logic [7:0] lane(input logic [7:0] x);
    lane = (link.word && !x[0]) ? link.wdata[15:8] : link.wdata[7:0];
  endfunction

  // Read value of one byte offset; the acquisition bytes are served only to word reads
  function automatic logic [7:0] rbyte(input logic [7:0] x);
    rbyte = 8'h00;
    if (x == `ADM_OFS_WUE) begin
      rbyte = wue;
    end else if (x == `ADM_OFS_MODE) begin
      rbyte = mode;
    end else if (x == `ADM_OFS_WSTAT) begin
      rbyte = wflag;
    end else if (x == `ADM_OFS_RSTAT) begin
      rbyte = {3'h0, cyc_flag, state, rst_flag};
    end else if (x == (`ADM_OFS_ACQ | 8'h01)) begin
      rbyte = {1'b0, acq[6:0]};
    end
  endfunction

  // Pins and reset sources cross in from other domains; second stage only is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 11'h000;
      sync_b <= 11'h000;
    end else begin
      sync_a <= {reset_source, cyclic_wake, wake_event};
      sync_b <= sync_a;
    end
  end

  assign ev = sync_b[7:0];
  assign cyc_ev = sync_b[8];
  assign rst_any = |sync_b[10:9];
  assign acc = link.req && !ack_q;
  assign base_ok = link.addr[15:8] == `ADM_BASE_BLOCK_HI || link.addr[15:8] == `ADM_BASE_NONBLOCK_HI;
  assign ofs = link.addr[7:0];
  assign low_power = state == adm_st_stop || state == adm_st_sleep;
  assign wake_hit = low_power ? (wue & ev) : 8'h00;
  assign cyc_hit = low_power && mode[`ADM_MODE_CYC_BIT] && cyc_ev;
  assign wake_any = |wake_hit || cyc_hit;
  // Processes see reads inside functions
  always_comb begin
    mode_wr = hit(ofs, `ADM_OFS_MODE) && !low_power;
    operating_mode_field = 2'(lane(`ADM_OFS_MODE));
  end
  assign acq_wr = acc && link.we && base_ok && link.word && ofs == `ADM_OFS_ACQ;

  // Mode sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adm_st_reset;
    end else if (rst_any) begin
      state <= adm_st_reset;
    end else begin
      unique case (state)
        adm_st_reset: begin
          state <= adm_st_normal;
        end
        adm_st_normal: begin
          if (mode_wr && operating_mode_field == `ADM_OPM_SLEEP) begin
            state <= adm_st_sleep;
          end else if (mode_wr && operating_mode_field == `ADM_OPM_STOP) begin
            state <= adm_st_stop_pend;
          end
        end
        adm_st_stop_pend: begin
          // Controller may still cancel before it actually stops
          if (mode_wr && operating_mode_field == `ADM_OPM_NORMAL) begin
            state <= adm_st_normal;
          end else if (mode_wr && operating_mode_field == `ADM_OPM_SLEEP) begin
            state <= adm_st_sleep;
          end else if (link.mcu_stopped) begin
            state <= adm_st_stop;
          end
        end
        adm_st_stop, adm_st_sleep: begin
          if (wake_any) begin
            state <= adm_st_intermediate;
          end
        end
        adm_st_intermediate: begin
          if (mode_wr && operating_mode_field == `ADM_OPM_NORMAL) begin
            state <= adm_st_normal;
          end else if (mode_wr && operating_mode_field == `ADM_OPM_SLEEP) begin
            state <= adm_st_sleep;
          end else if (mode_wr && operating_mode_field == `ADM_OPM_STOP) begin
            state <= adm_st_stop_pend;
          end
        end
        default: begin
          state <= adm_st_reset;
        end
      endcase
    end
  end

  // Clock source: link clock only once normal is entered, kept through a stop request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_link <= 1'b0;
    end else if (state == adm_st_normal) begin
      clk_link <= 1'b1;
    end else if (state != adm_st_stop_pend) begin
      clk_link <= 1'b0;
    end
  end

  // Configuration registers; the reset state restores defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wue <= `ADM_WUE_RESET;
      mode <= `ADM_MODE_RESET;
    end else if (state == adm_st_reset) begin
      wue <= `ADM_WUE_RESET;
      mode <= `ADM_MODE_RESET;
    end else begin
      if (hit(ofs, `ADM_OFS_WUE)) begin
        wue <= lane(`ADM_OFS_WUE);
      end
      if (hit(ofs, `ADM_OFS_MODE)) begin
        mode <= lane(`ADM_OFS_MODE) & 8'h07;
      end
    end
  end

  // Masked enables: each bit follows its write only when its mask bit is one
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_acq
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acq[gi] <= 1'b0;
        end else if (state == adm_st_reset) begin
          acq[gi] <= 1'(`ADM_ACQ_RESET >> gi);
        end else if (acq_wr && link.wdata[8 + gi]) begin
          acq[gi] <= link.wdata[gi];
        end else if (gi == `ADM_ACQ_AMP_HOUR_COUNTER_RESET_BIT) begin
          acq[gi] <= 1'b0; // Counter reset acts as a one-cycle strobe
        end
      end
    end
  endgenerate

  // Wake and reset cause flags; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wflag <= 8'h00;
      cyc_flag <= 1'b0;
      rst_flag <= 1'b1;
    end else begin
      wflag <= (wflag & ~(hit(ofs, `ADM_OFS_WSTAT) ? lane(`ADM_OFS_WSTAT) : 8'h00)) | wake_hit;
      cyc_flag <= (cyc_flag && !(hit(ofs, `ADM_OFS_RSTAT) && |(lane(`ADM_OFS_RSTAT) & 8'h10))) || cyc_hit;
      rst_flag <= (rst_flag && !(hit(ofs, `ADM_OFS_RSTAT) && |(lane(`ADM_OFS_RSTAT) & 8'h01))) || state == adm_st_reset;
    end
  end

  // Link answer one cycle after the request; byte reads of the word-only register give zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      link.rdata <= 16'h0000;
    end else begin
      ack_q <= acc;
      if (acc && !link.we) begin
        if (!base_ok) begin
          link.rdata <= 16'h0000;
        end else if (link.word) begin
          link.rdata <= {rbyte({ofs[7:1], 1'b0}), rbyte({ofs[7:1], 1'b1})};
        end else if (ofs[7:1] == `ADM_OFS_ACQ >> 1) begin
          link.rdata <= 16'h0000;
        end else begin
          link.rdata <= {8'h00, rbyte(ofs)};
        end
      end
    end
  end

  assign link.ack = ack_q;

  // Supplies, clocks and acquisition gating, registered from the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interface_supply_on <= 1'b1;
      controller_supply_on <= 1'b1;
      controller_supply_reduced <= 1'b0;
      analog_clock_on_link <= 1'b0;
      watchdog_enable <= 1'b0;
      analog_blocks_on <= 1'b1;
      current_meas_enable <= 1'b0;
      voltage_meas_enable <= 1'b0;
      internal_temp_meas_enable <= 1'b0;
      external_temp_meas_enable <= 1'b0;
      conversion_irq_enable <= 1'b0;
      open_detect_enable <= 1'b0;
      optional_input_select <= 1'b0;
      amp_hour_counter_reset <= 1'b0;
      link.wake_irq <= 1'b0;
      link.mcu_reset_n <= 1'b0;
    end else begin
      interface_supply_on <= !low_power;
      controller_supply_on <= state != adm_st_sleep;
      controller_supply_reduced <= state == adm_st_stop;
      analog_clock_on_link <= clk_link;
      watchdog_enable <= !low_power && state != adm_st_reset;
      analog_blocks_on <= !low_power;
      current_meas_enable <= acq[0];
      voltage_meas_enable <= acq[1] && !low_power;
      internal_temp_meas_enable <= acq[2];
      external_temp_meas_enable <= acq[3];
      conversion_irq_enable <= acq[4] && !low_power;
      open_detect_enable <= acq[5] && !low_power;
      optional_input_select <= acq[6];
      amp_hour_counter_reset <= acq[7];
      link.wake_irq <= state == adm_st_stop && wake_any;
      link.mcu_reset_n <= state != adm_st_reset;
    end
  end

  assign mode_state = state;
endmodule

`default_nettype wire

// ### adm_map.svh
// Offsets, field positions, reset values and link bases for the analog die mode control.
// Included by the package only, both ends use its macros; holds definitions only.
`ifndef ADM_MAP_SVH
`define ADM_MAP_SVH

// Die link address bases, upper address byte
`define ADM_BASE_BLOCK_HI 8'h02
`define ADM_BASE_NONBLOCK_HI 8'h03
`define ADM_BASE_BLOCK 16'h0200
`define ADM_BASE_NONBLOCK 16'h0300

// Device register byte offsets
`define ADM_OFS_WUE 8'h06
`define ADM_OFS_MODE 8'h08
`define ADM_OFS_WSTAT 8'h0a
`define ADM_OFS_RSTAT 8'h0b
`define ADM_OFS_ACQ 8'h58

// Device reset values
`define ADM_WUE_RESET 8'h00
`define ADM_ACQ_RESET 8'h00
`define ADM_MODE_RESET 8'h00

// Operating mode field encodings
`define ADM_OPM_NORMAL 2'h0
`define ADM_OPM_STOP 2'h1
`define ADM_OPM_SLEEP 2'h2

// Field positions
`define ADM_WUE_EXT3_BIT 3
`define ADM_ACQ_EXTERNAL_TEMP_MEAS_ENABLE_BIT 3
`define ADM_ACQ_OPTIONAL_INPUT_SELECT_BIT 6
`define ADM_ACQ_AMP_HOUR_COUNTER_RESET_BIT 7
`define ADM_MODE_CYC_BIT 2

// Controller APB register offsets
`define ADM_APB_CMD 12'h000
`define ADM_APB_WDATA 12'h004
`define ADM_APB_STAT 12'h008
`define ADM_APB_CTRL 12'h00c

`endif

// ### adm_pkg.sv
// Types shared by both ends of the analog die mode control.
// Expects adm_map.svh on the include path.
`include "adm_map.svh"

package adm_pkg;
  typedef logic [15:0] adm_addr_t;
  typedef logic [15:0] adm_data_t;
  typedef enum logic [2:0] {
    adm_st_reset,
    adm_st_normal,
    adm_st_stop_pend,
    adm_st_stop,
    adm_st_sleep,
    adm_st_intermediate
  } adm_state_e;
endpackage

// ### adm_link_if.sv
// Die-to-die link between the controller end and the analog die end.
// Both ends run on the same pclk; the bench connects the two modports.
`timescale 1ns/1ps
`default_nettype none

interface adm_link_if;
  import adm_pkg::*;
  logic req;
  logic we;
  logic word;
  adm_addr_t addr;
  adm_data_t wdata;
  logic ack;
  adm_data_t rdata;
  logic mcu_stopped;
  logic wake_irq;
  logic mcu_reset_n;

  modport device (
    input req, we, word, addr, wdata, mcu_stopped,
    output ack, rdata, wake_irq, mcu_reset_n
  );
  modport controller (
    output req, we, word, addr, wdata, mcu_stopped,
    input ack, rdata, wake_irq, mcu_reset_n
  );
endinterface

`default_nettype wire

// ### adm_controller.sv
// Controller end: APB registers that issue die link accesses and report results.
// Assumes one pclk domain shared with the analog die end.
`timescale 1ns/1ps
`default_nettype none

module adm_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reduced_option,
  adm_link_if.controller link
);
  import adm_pkg::*;

  logic opt_a;
  logic opt_b;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic wake_seen;
  logic wr;
  logic rd_setup;
  logic [7:0] cofs;
  logic cword;
  logic [15:0] cmask;

  // Strap pin crosses in; only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_a <= 1'b0;
      opt_b <= 1'b0;
    end else begin
      opt_a <= reduced_option;
      opt_b <= opt_a;
    end
  end

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign cofs = pwdata[7:0];
  assign cword = pwdata[17] || cofs[7:1] == `ADM_OFS_ACQ >> 1;

  // Bits the reduced option must never set: ext input 3 wake, ext temp, optional input
  always_comb begin
    cmask = 16'hffff;
    if (opt_b && cofs == `ADM_OFS_WUE) begin
      cmask[(cword ? 8 : 0) + `ADM_WUE_EXT3_BIT] = 1'b0;
    end
    if (opt_b && cofs[7:1] == `ADM_OFS_ACQ >> 1) begin
      cmask[`ADM_ACQ_EXTERNAL_TEMP_MEAS_ENABLE_BIT] = 1'b0;
      cmask[`ADM_ACQ_OPTIONAL_INPUT_SELECT_BIT] = 1'b0;
    end
  end

  // Link request launch and completion; a command while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.word <= 1'b0;
      link.addr <= 16'h0000;
      link.wdata <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else if (link.req) begin
      if (link.ack) begin
        link.req <= 1'b0;
        if (!link.we) begin
          rdata_reg <= link.rdata;
        end
      end
    end else if (wr && paddr == `ADM_APB_CMD) begin
      link.req <= 1'b1;
      link.we <= pwdata[16];
      link.word <= cword;
      link.addr <= (pwdata[8] ? `ADM_BASE_NONBLOCK : `ADM_BASE_BLOCK) | {8'h00, cofs};
      link.wdata <= wdata_reg & cmask;
    end
  end

  // Write data, stop indication and the sticky wake flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_reg <= 16'h0000;
      link.mcu_stopped <= 1'b0;
      wake_seen <= 1'b0;
    end else begin
      if (wr && paddr == `ADM_APB_WDATA) begin
        wdata_reg <= pwdata[15:0];
      end
      if (wr && paddr == `ADM_APB_CTRL) begin
        link.mcu_stopped <= pwdata[0];
      end
      // Wake pulse wins over a same-cycle clear
      wake_seen <= (wake_seen && !(wr && paddr == `ADM_APB_STAT && pwdata[1])) || link.wake_irq;
    end
  end

  // Read data captured in the setup cycle so it is stable for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        `ADM_APB_WDATA: prdata <= {16'h0000, wdata_reg};
        `ADM_APB_STAT: prdata <= {rdata_reg, 12'h000, opt_b, link.mcu_reset_n, wake_seen, link.req};
        `ADM_APB_CTRL: prdata <= {31'h0000_0000, link.mcu_stopped};
        `ADM_APB_CMD: prdata <= {13'h0000, link.word, link.we, link.addr[8], link.addr};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule

`default_nettype wire

// ### adm_link_checker.sv
// Concurrent checks on the die link between the controller end and the analog die end.
// Assumes one pclk domain and the asynchronous active-low presetn shared by both ends.
`timescale 1ns/1ps
`default_nettype none

module adm_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic word,
  input wire adm_pkg::adm_addr_t addr,
  input wire adm_pkg::adm_data_t wdata,
  input wire logic ack,
  input wire adm_pkg::adm_data_t rdata,
  input wire logic mcu_stopped,
  input wire logic wake_irq,
  input wire logic mcu_reset_n
);
  import adm_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Acquisition word on either base; byte lanes there would split an update
  logic to_acq;
  assign to_acq = (addr[15:8] == 8'h02 || addr[15:8] == 8'h03) && addr[7:1] == 7'h2c;

  // Link handshake: taken one edge after req rises, answered once
  property p_req_taken;
    $rose(req) |=> ack;
  endproperty
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  property p_ack_in_req;
    ack |-> req;
  endproperty
  property p_req_held;
    req && !ack |=> req && $stable({we, word, addr, wdata});
  endproperty
  property p_req_drop;
    req && ack |=> !req;
  endproperty
  // Word access rules
  property p_acq_word;
    req && to_acq |-> word;
  endproperty
  property p_word_even;
    req && word |-> !addr[0];
  endproperty
  // Read data only moves with an answer
  property p_rdata_hold;
    $changed(rdata) |-> ack;
  endproperty
  // Wake interrupt only after the controller stopped the link
  property p_stop_wake;
    wake_irq |-> mcu_stopped;
  endproperty
  // Controller reset released two edges after the die leaves reset
  property p_reset_release;
    $rose(presetn) |-> !mcu_reset_n ##2 mcu_reset_n;
  endproperty

  a_req_taken: assert property (p_req_taken) else $error("link request not answered");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_in_req: assert property (p_ack_in_req) else $error("ack without request");
  a_req_held: assert property (p_req_held) else $error("request changed before ack");
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  a_acq_word: assert property (p_acq_word) else $error("byte access to acquisition word");
  a_word_even: assert property (p_word_even) else $error("word access on odd address");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without ack");
  a_stop_wake: assert property (p_stop_wake) else $error("wake interrupt outside stop");
  a_reset_release: assert property (p_reset_release) else $error("controller reset release late");

  c_write: cover property (req && we && ack);
  c_acq: cover property (req && to_acq && ack);
  c_wake: cover property (wake_irq);
endmodule

`default_nettype wire

// ### analog_die_mode_control_tb_top.sv
// Testbench joining the controller end and the analog die end over the die link.
// Assumes APB software access to the controller and a single 250 MHz pclk.
`timescale 1ns/1ps
`default_nettype none

module analog_die_mode_control_tb_top;
  import adm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reduced_option, cyclic_wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, t;
  logic [7:0] wake_event;
  logic [1:0] reset_source;
  logic if_sup, ctl_sup, ctl_red, clk_link, wdog, ablk, cme, vme, itme, etme, cie, ode, ois, ahr;
  logic [15:0] rd;
  adm_state_e mode_state;
  int num_errors = 0, checks_done = 0, cycles = 0, ah_cnt = 0, irq_cnt = 0;

  adm_link_if link_if();
  adm_controller i_adm_controller (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reduced_option(reduced_option), .link(link_if));
  adm_device i_adm_device (.pclk(pclk), .presetn(presetn), .link(link_if), .wake_event(wake_event),
    .cyclic_wake(cyclic_wake), .reset_source(reset_source), .interface_supply_on(if_sup),
    .controller_supply_on(ctl_sup), .controller_supply_reduced(ctl_red), .analog_clock_on_link(clk_link),
    .watchdog_enable(wdog), .analog_blocks_on(ablk), .current_meas_enable(cme), .voltage_meas_enable(vme),
    .internal_temp_meas_enable(itme), .external_temp_meas_enable(etme), .conversion_irq_enable(cie),
    .open_detect_enable(ode), .optional_input_select(ois), .amp_hour_counter_reset(ahr),
    .mode_state(mode_state));
  adm_link_checker i_adm_link_checker (.pclk(pclk), .presetn(presetn), .req(link_if.req), .we(link_if.we),
    .word(link_if.word), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata),
    .mcu_stopped(link_if.mcu_stopped), .wake_irq(link_if.wake_irq), .mcu_reset_n(link_if.mcu_reset_n));

  // Clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Pulse counters; a pulse is one cycle, so counting levels counts pulses
  always @(posedge pclk) begin
    if (ahr === 1'b1) ah_cnt++;
    if (link_if.wake_irq === 1'b1) irq_cnt++;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      give_verdict();
    end
  end

  task give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task check_val(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; pready is sampled at each access edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One die link access through the controller registers, polled until idle
  task link(input logic wr, input logic wd, input logic nb, input logic [7:0] ofs, input logic [15:0] d,
            output logic [15:0] r);
    logic [31:0] s;
    int n;
    apb(1'b1, 12'h004, {16'h0, d}, s);
    apb(1'b1, 12'h000, {14'h0, wd, wr, 7'h0, nb, ofs}, s);
    n = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 50);
    r = s[31:16];
  endtask

  // Bounded wait for a state, then outputs get their registered cycle
  task wait_state(input adm_state_e s);
    int n;
    n = 0;
    while (mode_state !== s && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check_val(32'(mode_state), 32'(s), "mode state");
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    reduced_option = 1'b0; cyclic_wake = 1'b0; wake_event = 8'h00; reset_source = 2'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_state(adm_st_normal);
    check_val({26'h0, if_sup, ctl_sup, ctl_red, clk_link, wdog, ablk}, 32'h37, "normal outputs");
    link(1'b0, 1'b0, 1'b0, 8'h06, 16'h0, rd);
    check_val({24'h0, rd[7:0]}, 32'h0, "wake enable reset");
    link(1'b0, 1'b1, 1'b0, 8'h58, 16'h0, rd);
    check_val({16'h0, rd}, 32'h0, "acq reset");
    apb(1'b0, 12'h010, 32'h0, t);
    check_val({t[31:1], t[0] | pslverr}, 32'h0, "unmapped apb read");
    $display("Test reset values done");
    // Both bases reach the same register; word write takes the even lane
    link(1'b1, 1'b0, 1'b0, 8'h06, 16'h00a5, rd);
    link(1'b0, 1'b0, 1'b1, 8'h06, 16'h0, rd);
    check_val({24'h0, rd[7:0]}, 32'ha5, "wake enable via other base");
    link(1'b1, 1'b1, 1'b1, 8'h06, 16'h5a00, rd);
    link(1'b0, 1'b0, 1'b0, 8'h06, 16'h0, rd);
    check_val({24'h0, rd[7:0]}, 32'h5a, "wake enable word write");
    $display("Test bases done");
    // Masked enables, write-only masks, strobe bit
    link(1'b1, 1'b1, 1'b0, 8'h58, 16'hff13, rd);
    @(posedge pclk);
    check_val({25'h0, ois, ode, cie, etme, itme, vme, cme}, 32'h13, "acq outputs");
    link(1'b1, 1'b1, 1'b0, 8'h58, 16'h0200, rd);
    link(1'b1, 1'b1, 1'b0, 8'h58, 16'h8080, rd);
    link(1'b0, 1'b1, 1'b1, 8'h58, 16'h0, rd);
    check_val({16'h0, rd}, 32'h0011, "acq masked update");
    check_val({25'h0, ois, ode, cie, etme, itme, vme, cme}, 32'h11, "acq outputs masked");
    check_val(32'(ah_cnt), 32'h1, "amp hour reset pulses");
    $display("Test acquisition done");
    // Reduced option strips unavailable features from outgoing data
    reduced_option <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0, t);
    check_val({31'h0, t[3]}, 32'h1, "reduced option seen");
    link(1'b1, 1'b0, 1'b0, 8'h06, 16'h00ff, rd);
    link(1'b0, 1'b0, 1'b0, 8'h06, 16'h0, rd);
    check_val({24'h0, rd[7:0]}, 32'hf7, "reduced wake enable");
    link(1'b1, 1'b1, 1'b0, 8'h58, 16'hff7f, rd);
    link(1'b0, 1'b1, 1'b0, 8'h58, 16'h0, rd);
    check_val({16'h0, rd}, 32'h0037, "reduced acq");
    check_val({30'h0, ois, etme}, 32'h0, "reduced acq outputs");
    reduced_option <= 1'b0;
    $display("Test reduced option done");
    // Sleep, ignored disabled source, wake through intermediate
    link(1'b1, 1'b0, 1'b0, 8'h06, 16'h0010, rd);
    link(1'b1, 1'b0, 1'b0, 8'h08, 16'h0002, rd);
    wait_state(adm_st_sleep);
    check_val({28'h0, if_sup, ctl_sup, wdog, clk_link}, 32'h0, "sleep outputs");
    check_val({29'h0, cme, vme, itme}, 32'h5, "sleep measurements");
    wake_event <= 8'h01;
    repeat (8) @(posedge pclk);
    check_val(32'(mode_state), 32'(adm_st_sleep), "disabled source ignored");
    wake_event <= 8'h10;
    wait_state(adm_st_intermediate);
    wake_event <= 8'h00;
    check_val({31'h0, clk_link}, 32'h0, "intermediate clock");
    link(1'b0, 1'b1, 1'b0, 8'h0a, 16'h0, rd);
    check_val({16'h0, rd}, 32'h100b, "wake and reset flags");
    link(1'b1, 1'b0, 1'b0, 8'h0a, 16'h0010, rd);
    link(1'b0, 1'b0, 1'b0, 8'h0a, 16'h0, rd);
    check_val({24'h0, rd[7:0]}, 32'h0, "wake flag cleared");
    link(1'b1, 1'b0, 1'b0, 8'h08, 16'h0000, rd);
    wait_state(adm_st_normal);
    check_val({30'h0, clk_link, if_sup}, 32'h3, "normal again");
    check_val(32'(irq_cnt), 32'h0, "no interrupt from sleep");
    $display("Test sleep done");
    // Stop waits for the stopped link, then intermediate back to sleep
    link(1'b1, 1'b0, 1'b0, 8'h08, 16'h0001, rd);
    wait_state(adm_st_stop_pend);
    apb(1'b1, 12'h00c, 32'h1, t);
    apb(1'b0, 12'h00c, 32'h0, t);
    check_val(t, 32'h1, "stop flag readback");
    wait_state(adm_st_stop);
    check_val({28'h0, if_sup, ctl_sup, ctl_red, wdog}, 32'h6, "stop outputs");
    wake_event <= 8'h10;
    wait_state(adm_st_intermediate);
    wake_event <= 8'h00;
    check_val(32'(irq_cnt), 32'h1, "wake interrupt");
    apb(1'b0, 12'h008, 32'h0, t);
    check_val({31'h0, t[1]}, 32'h1, "wake seen");
    link(1'b1, 1'b0, 1'b0, 8'h0a, 16'h0010, rd);
    link(1'b1, 1'b0, 1'b0, 8'h08, 16'h0006, rd);
    wait_state(adm_st_sleep);
    check_val({31'h0, clk_link}, 32'h0, "clock kept off link");
    cyclic_wake <= 1'b1;
    wait_state(adm_st_intermediate);
    cyclic_wake <= 1'b0;
    apb(1'b1, 12'h00c, 32'h0, t);
    link(1'b1, 1'b0, 1'b0, 8'h08, 16'h0000, rd);
    wait_state(adm_st_normal);
    $display("Test stop done");
    // Internal reset source clears the registers
    reset_source <= 2'h2;
    wait_state(adm_st_reset);
    check_val({31'h0, link_if.mcu_reset_n}, 32'h0, "controller held in reset");
    reset_source <= 2'h0;
    wait_state(adm_st_normal);
    repeat (3) @(posedge pclk);
    link(1'b0, 1'b0, 1'b0, 8'h06, 16'h0, rd);
    check_val({24'h0, rd[7:0]}, 32'h0, "wake enable after reset");
    $display("Test reset source done");
    give_verdict();
  end
endmodule

`default_nettype wire
